// ===== dspm_params.svh
`ifndef DSPM_PARAMS_SVH
`define DSPM_PARAMS_SVH

// Width of the port C control vectors.
`define DSPM_PORT_W 16
// Port C bit position of the shared index pin.
`define DSPM_INDEX_BIT 4'h2
// Port C bit position of the shared home pin.
`define DSPM_HOME_BIT 4'h3
// Number of synchronised pad inputs.
`define DSPM_SYNC_W 2
// Reset level of every single-bit state flop.
`define DSPM_BIT_RST 1'h0

`endif

// ===== dspm_pkg.sv
// Types shared by the shared-pin mux and its synchroniser.
package dspm_pkg;

	// Function that a shared pin is connected to.
	typedef enum logic [2:0] {
		DSPM_FN_NONE,
		DSPM_FN_DECODER,
		DSPM_FN_TIMER,
		DSPM_FN_SPI,
		DSPM_FN_GPIO
	} dspm_func_t;

	// Whole state of the mux: selections, pad drive and core-side inputs.
	typedef struct packed {
		dspm_func_t index_fn;
		dspm_func_t home_fn;
		logic miso_bit;
		logic idx_o;
		logic idx_oe;
		logic home_o;
		logic home_oe;
		logic idx_pu;
		logic home_pu;
		logic dec_index;
		logic dec_home;
		logic tb2_in;
		logic tb3_in;
		logic gpio2_in;
		logic gpio3_in;
		logic miso_in;
		logic slave_sel;
		logic mode_fault;
	} dspm_state_t;

	// State of the two-flop synchroniser.
	typedef struct packed {
		logic [1:0] first;
		logic [1:0] second;
	} dspm_sync_t;

endpackage

// ===== dspm_sync.sv
`timescale 1ns/100ps
`include "dspm_params.svh"

// Two-flop synchroniser for the shared pad inputs.
module dspm_sync (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [`DSPM_SYNC_W-1:0] d_i,
	output logic [`DSPM_SYNC_W-1:0] q_o
);

	dspm_pkg::dspm_sync_t s_r; // Registered synchroniser state.
	dspm_pkg::dspm_sync_t s_nxt; // Next synchroniser state.

	// The first stage is read only by the second stage.
	always_comb begin
		s_nxt = s_r;
		s_nxt.first = d_i;
		s_nxt.second = s_r.first;
	end

	// Both stages clear on synchronous reset.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.second;

endmodule

// ===== dspm_mux.sv
`timescale 1ns/100ps
`include "dspm_params.svh"

// Contract
// RULE_01: Index_pin_alt_select bit set routes SPI slave-out.
// RULE_02: Home_pin_alt_select bit set routes SPI select.
// RULE_03: Slave-out floats while slave not selected.
// RULE_04: Slave bit launched half period before sampling.
// RULE_05: Full variant resets index pin to decoder.
// RULE_06: Full variant resets home pin to decoder.
// RULE_07: Reduced variant resets to none; software reprograms.
// RULE_08: Clearing pull-up bit 2 disables index pull-up.
// RULE_09: Setting pull-up bit 3 disables home pull-up.
// RULE_10: Select is slave input or master arbitration.
// RULE_11: GPIO pins individually input or output.
// RULE_12: Alt clear routes decoder, timer or GPIO.
module dspm_mux #(
	parameter int PORT_W = `DSPM_PORT_W,
	parameter bit FULL_VARIANT = 1'b1
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic cfg_load_i,
	input wire logic index_pin_alt_select_i,
	input wire logic home_pin_alt_select_i,
	input wire logic [PORT_W-1:0] periph_enable_i,
	input wire logic [PORT_W-1:0] timer_select_i,
	input wire logic [PORT_W-1:0] port_c_pullup_enable_reg_i,
	input wire logic [PORT_W-1:0] gpio_dir_i,
	input wire logic [PORT_W-1:0] gpio_data_i,
	input wire logic timer_b_ch2_out_i,
	input wire logic timer_b_ch2_oe_i,
	input wire logic timer_b_ch3_out_i,
	input wire logic timer_b_ch3_oe_i,
	input wire logic spi_slave_mode_i,
	input wire logic spi_slave_out_bit_i,
	input wire logic spi_launch_i,
	input wire logic index_pad_i,
	output logic index_pad_o,
	output logic index_pad_oe_o,
	output logic index_pullup_o,
	input wire logic home_pad_i,
	output logic home_pad_o,
	output logic home_pad_oe_o,
	output logic home_pullup_o,
	output logic decoder_index_in_o,
	output logic decoder_home_in_o,
	output logic timer_b_ch2_in_o,
	output logic timer_b_ch3_in_o,
	output logic port_c_pin2_in_o,
	output logic port_c_pin3_in_o,
	output logic spi1_master_in_o,
	output logic spi1_slave_select_o,
	output logic spi1_mode_fault_o
);

	// Reset selection of both pins depends on the variant.
	localparam dspm_pkg::dspm_func_t RST_FN =
		FULL_VARIANT ? dspm_pkg::DSPM_FN_DECODER : dspm_pkg::DSPM_FN_NONE;

	dspm_pkg::dspm_state_t s_r; // Registered mux state.
	dspm_pkg::dspm_state_t s_nxt; // Next mux state.
	logic [`DSPM_SYNC_W-1:0] pad_q; // Synchronised pads, index in bit 0.
	logic idx_q; // Synchronised index pad level.
	logic home_q; // Synchronised home pad level.
	logic ss_act; // Select pin routed to SPI and driven low.

	// Chooses the function of one pin from its alternate and enable bits.
	function automatic dspm_pkg::dspm_func_t dspm_pick(input logic alt, input logic pen,
			input logic tsel);
		if (alt) begin
			dspm_pick = dspm_pkg::DSPM_FN_SPI; // [RULE_01] [RULE_02]
		end else if (!pen) begin
			dspm_pick = dspm_pkg::DSPM_FN_GPIO; // [RULE_12]
		end else if (tsel) begin
			dspm_pick = dspm_pkg::DSPM_FN_TIMER; // [RULE_12]
		end else begin
			dspm_pick = dspm_pkg::DSPM_FN_DECODER; // [RULE_12]
		end
	endfunction

	// Pads are asynchronous to the system clock, so they are synchronised first.
	dspm_sync u_sync (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.d_i({home_pad_i, index_pad_i}),
		.q_o(pad_q)
	);

	assign idx_q = pad_q[0];
	assign home_q = pad_q[1];
	assign ss_act = (s_r.home_fn == dspm_pkg::DSPM_FN_SPI) && !home_q;

	// Computes the next selection, pad drive and core-side inputs.
	always_comb begin
		s_nxt = s_r;
		// A configuration load takes the new selection for both pins.
		if (cfg_load_i) begin
			s_nxt.index_fn = dspm_pick(index_pin_alt_select_i,
				periph_enable_i[`DSPM_INDEX_BIT], timer_select_i[`DSPM_INDEX_BIT]);
			s_nxt.home_fn = dspm_pick(home_pin_alt_select_i,
				periph_enable_i[`DSPM_HOME_BIT], timer_select_i[`DSPM_HOME_BIT]);
		end
		// The core pulses launch on the edge opposite the master's sampling edge.
		if (spi_launch_i && spi_slave_mode_i) begin
			s_nxt.miso_bit = spi_slave_out_bit_i; // [RULE_04]
		end
		// Index pad drive follows the selected function.
		unique case (s_r.index_fn)
			dspm_pkg::DSPM_FN_TIMER: begin
				s_nxt.idx_o = timer_b_ch2_out_i;
				s_nxt.idx_oe = timer_b_ch2_oe_i;
			end
			dspm_pkg::DSPM_FN_SPI: begin
				s_nxt.idx_o = s_r.miso_bit; // [RULE_04]
				s_nxt.idx_oe = spi_slave_mode_i && ss_act; // [RULE_03]
			end
			dspm_pkg::DSPM_FN_GPIO: begin
				s_nxt.idx_o = gpio_data_i[`DSPM_INDEX_BIT];
				s_nxt.idx_oe = gpio_dir_i[`DSPM_INDEX_BIT]; // [RULE_11]
			end
			dspm_pkg::DSPM_FN_DECODER, dspm_pkg::DSPM_FN_NONE: begin
				s_nxt.idx_o = `DSPM_BIT_RST;
				s_nxt.idx_oe = `DSPM_BIT_RST;
			end
		endcase
		// Home pad drive; the select function is input only.
		unique case (s_r.home_fn)
			dspm_pkg::DSPM_FN_TIMER: begin
				s_nxt.home_o = timer_b_ch3_out_i;
				s_nxt.home_oe = timer_b_ch3_oe_i;
			end
			dspm_pkg::DSPM_FN_GPIO: begin
				s_nxt.home_o = gpio_data_i[`DSPM_HOME_BIT];
				s_nxt.home_oe = gpio_dir_i[`DSPM_HOME_BIT]; // [RULE_11]
			end
			dspm_pkg::DSPM_FN_SPI, dspm_pkg::DSPM_FN_DECODER, dspm_pkg::DSPM_FN_NONE: begin
				s_nxt.home_o = `DSPM_BIT_RST;
				s_nxt.home_oe = `DSPM_BIT_RST;
			end
		endcase
		// Pull-ups: index bit is an enable, home bit is a disable.
		s_nxt.idx_pu = port_c_pullup_enable_reg_i[`DSPM_INDEX_BIT]; // [RULE_08]
		s_nxt.home_pu = !port_c_pullup_enable_reg_i[`DSPM_HOME_BIT]; // [RULE_09]
		// Pad levels reach only the core that owns the pin.
		s_nxt.dec_index = (s_r.index_fn == dspm_pkg::DSPM_FN_DECODER) && idx_q;
		s_nxt.dec_home = (s_r.home_fn == dspm_pkg::DSPM_FN_DECODER) && home_q;
		s_nxt.tb2_in = (s_r.index_fn == dspm_pkg::DSPM_FN_TIMER) && idx_q;
		s_nxt.tb3_in = (s_r.home_fn == dspm_pkg::DSPM_FN_TIMER) && home_q;
		s_nxt.gpio2_in = (s_r.index_fn == dspm_pkg::DSPM_FN_GPIO) && idx_q;
		s_nxt.gpio3_in = (s_r.home_fn == dspm_pkg::DSPM_FN_GPIO) && home_q;
		s_nxt.miso_in = (s_r.index_fn == dspm_pkg::DSPM_FN_SPI) && !spi_slave_mode_i && idx_q;
		// Select is the slave's enable, or a mode fault for a master.
		s_nxt.slave_sel = spi_slave_mode_i && ss_act; // [RULE_10]
		s_nxt.mode_fault = !spi_slave_mode_i && ss_act; // [RULE_10]
	end

	// Registers the state; reset applies the variant's default selection.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
			s_r.index_fn <= RST_FN; // [RULE_05] [RULE_07]
			s_r.home_fn <= RST_FN; // [RULE_06] [RULE_07]
		end else begin
			s_r <= s_nxt;
		end
	end

	assign index_pad_o = s_r.idx_o;
	assign index_pad_oe_o = s_r.idx_oe;
	assign index_pullup_o = s_r.idx_pu;
	assign home_pad_o = s_r.home_o;
	assign home_pad_oe_o = s_r.home_oe;
	assign home_pullup_o = s_r.home_pu;
	assign decoder_index_in_o = s_r.dec_index;
	assign decoder_home_in_o = s_r.dec_home;
	assign timer_b_ch2_in_o = s_r.tb2_in;
	assign timer_b_ch3_in_o = s_r.tb3_in;
	assign port_c_pin2_in_o = s_r.gpio2_in;
	assign port_c_pin3_in_o = s_r.gpio3_in;
	assign spi1_master_in_o = s_r.miso_in;
	assign spi1_slave_select_o = s_r.slave_sel;
	assign spi1_mode_fault_o = s_r.mode_fault;

	// A slave launch with the index pin held on SPI.
	sequence launch_s;
		spi_launch_i && spi_slave_mode_i && !cfg_load_i &&
			(s_r.index_fn == dspm_pkg::DSPM_FN_SPI);
	endsequence

	chk_index_spi_route: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_01]
		cfg_load_i && index_pin_alt_select_i |=> s_r.index_fn == dspm_pkg::DSPM_FN_SPI)
		else $error("Index pin not routed to SPI.");
	chk_home_spi_route: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_02]
		cfg_load_i && home_pin_alt_select_i |=> s_r.home_fn == dspm_pkg::DSPM_FN_SPI)
		else $error("Home pin not routed to SPI.");
	chk_miso_float: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_03]
		(s_r.index_fn == dspm_pkg::DSPM_FN_SPI) && !(spi_slave_mode_i && ss_act)
		|=> !index_pad_oe_o)
		else $error("Slave-out driven while not selected.");
	chk_miso_launch: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_04]
		launch_s |=> ##1 (index_pad_o == $past(spi_slave_out_bit_i, 2)))
		else $error("Launched slave bit not on pad.");
	chk_index_reset: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_05]
		$rose(reset_n_i) |-> s_r.index_fn == RST_FN)
		else $error("Index pin reset selection wrong.");
	chk_home_reset: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_06]
		$rose(reset_n_i) |-> s_r.home_fn == RST_FN)
		else $error("Home pin reset selection wrong.");
	chk_index_pullup: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_08]
		!port_c_pullup_enable_reg_i[`DSPM_INDEX_BIT] |=> !index_pullup_o)
		else $error("Index pull-up not disabled.");
	chk_home_pullup: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_09]
		port_c_pullup_enable_reg_i[`DSPM_HOME_BIT] |=> !home_pullup_o)
		else $error("Home pull-up not disabled.");
	chk_ss_arbitration: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_10]
		ss_act && !spi_slave_mode_i |=> spi1_mode_fault_o && !spi1_slave_select_o)
		else $error("Master select did not flag arbitration.");
	chk_gpio_dir: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_11]
		s_r.index_fn == dspm_pkg::DSPM_FN_GPIO
		|=> index_pad_oe_o == $past(gpio_dir_i[`DSPM_INDEX_BIT]))
		else $error("GPIO direction not applied.");
	chk_gpio_fallback: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE_12]
		cfg_load_i && !index_pin_alt_select_i && !periph_enable_i[`DSPM_INDEX_BIT]
		|=> s_r.index_fn == dspm_pkg::DSPM_FN_GPIO)
		else $error("Index pin not routed to GPIO.");

endmodule

// ===== dspm_peer.sv
`timescale 1ns/100ps

// Far side of the two shared pins: an encoder or SPI peer that may drive either line.
module dspm_peer (
	input wire logic clock_i,
	input wire logic idx_o_i,
	input wire logic idx_oe_i,
	input wire logic idx_pu_i,
	input wire logic home_o_i,
	input wire logic home_oe_i,
	input wire logic home_pu_i,
	input wire logic idx_en_i,
	input wire logic idx_v_i,
	input wire logic home_en_i,
	input wire logic home_v_i,
	output logic idx_w_o,
	output logic home_w_o
);
	// Last line levels, kept for when nobody drives a line.
	logic idx_last_r = 1'h0;
	logic home_last_r = 1'h0;

	// A floating line without pull-up flips each cycle, so no stale level passes for data.
	always @(posedge clock_i) begin
		idx_last_r <= idx_w_o;
		home_last_r <= home_w_o;
	end

	// The peer drives the data line only while it acts as encoder or as a selected slave.
	assign idx_w_o = idx_oe_i ? idx_o_i : idx_en_i ? idx_v_i :
		idx_pu_i ? 1'h1 : ~idx_last_r;
	assign home_w_o = home_oe_i ? home_o_i : home_en_i ? home_v_i :
		home_pu_i ? 1'h1 : ~home_last_r;
endmodule

// ===== testbench.sv
`timescale 1ns/100ps

// Compares a design value with its expectation and counts the outcome.
`define CHK(g, e) begin tests_run++; \
	if ((g) !== (e)) begin err_total++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end

module testbench;
	// Stimulus, changed at the falling edge only.
	logic clock_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic ld = 1'h0, ia = 1'h0, ha = 1'h0, smode = 1'h0, sbit = 1'h0, lch = 1'h0;
	logic t2o = 1'h0, t2e = 1'h0, t3o = 1'h0, t3e = 1'h0;
	logic [15:0] pe = 16'h0000, ts = 16'h0000, pur = 16'h0000, dir = 16'h0000, dat = 16'h0000;
	// Peer drive requests for the index and home lines.
	logic ie = 1'h0, iv = 1'h0, he = 1'h0, hv = 1'h0;
	// Mux outputs and resolved line levels.
	logic ipo, ioe, ipu, hpo, hoe, hpu, dix, dho, t2i, t3i, g2, g3, mi, ss, mf, iw, hw;
	// Outputs of the reduced variant that the bench watches.
	logic r_ioe, r_dix, r_dho, r_g3;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;

	// Clock of 50 ns period.
	always #25 clock_i = ~clock_i;

	dspm_mux #(.PORT_W(16), .FULL_VARIANT(1'b1)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.cfg_load_i(ld), .index_pin_alt_select_i(ia), .home_pin_alt_select_i(ha),
		.periph_enable_i(pe), .timer_select_i(ts), .port_c_pullup_enable_reg_i(pur),
		.gpio_dir_i(dir), .gpio_data_i(dat), .timer_b_ch2_out_i(t2o), .timer_b_ch2_oe_i(t2e),
		.timer_b_ch3_out_i(t3o), .timer_b_ch3_oe_i(t3e), .spi_slave_mode_i(smode),
		.spi_slave_out_bit_i(sbit), .spi_launch_i(lch), .index_pad_i(iw), .index_pad_o(ipo),
		.index_pad_oe_o(ioe), .index_pullup_o(ipu), .home_pad_i(hw), .home_pad_o(hpo),
		.home_pad_oe_o(hoe), .home_pullup_o(hpu), .decoder_index_in_o(dix),
		.decoder_home_in_o(dho), .timer_b_ch2_in_o(t2i), .timer_b_ch3_in_o(t3i),
		.port_c_pin2_in_o(g2), .port_c_pin3_in_o(g3), .spi1_master_in_o(mi),
		.spi1_slave_select_o(ss), .spi1_mode_fault_o(mf));

	dspm_peer peer (.clock_i(clock_i), .idx_o_i(ipo), .idx_oe_i(ioe), .idx_pu_i(ipu),
		.home_o_i(hpo), .home_oe_i(hoe), .home_pu_i(hpu), .idx_en_i(ie), .idx_v_i(iv),
		.home_en_i(he), .home_v_i(hv), .idx_w_o(iw), .home_w_o(hw));

	// Reduced variant beside the full one: its pad drives and core inputs stay off until a selection is loaded.
	dspm_mux #(.PORT_W(16), .FULL_VARIANT(1'b0)) dut_red (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .cfg_load_i(ld), .index_pin_alt_select_i(ia),
		.home_pin_alt_select_i(ha), .periph_enable_i(pe), .timer_select_i(ts),
		.port_c_pullup_enable_reg_i(pur), .gpio_dir_i(dir), .gpio_data_i(dat),
		.timer_b_ch2_out_i(t2o), .timer_b_ch2_oe_i(t2e), .timer_b_ch3_out_i(t3o),
		.timer_b_ch3_oe_i(t3e), .spi_slave_mode_i(smode), .spi_slave_out_bit_i(sbit),
		.spi_launch_i(lch), .index_pad_i(iw), .index_pad_o(), .index_pad_oe_o(r_ioe),
		.index_pullup_o(), .home_pad_i(hw), .home_pad_o(), .home_pad_oe_o(),
		.home_pullup_o(), .decoder_index_in_o(r_dix), .decoder_home_in_o(r_dho),
		.timer_b_ch2_in_o(), .timer_b_ch3_in_o(), .port_c_pin2_in_o(),
		.port_c_pin3_in_o(r_g3), .spi1_master_in_o(), .spi1_slave_select_o(),
		.spi1_mode_fault_o());

	// Waits a number of falling edges.
	task step(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	// Pulses the selection strobe, then lets the pad synchronisers settle.
	task load();
		ld = 1'h1;
		step(1);
		ld = 1'h0;
		step(4);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Cuts a hang short; the whole run needs about sixty cycles.
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			stop_test();
		end
	end

	// Decoder inputs and pull-ups straight out of reset.
	task t_reset();
		ie = 1'h1; iv = 1'h1; he = 1'h1; hv = 1'h0; pur = 16'h0004;
		step(10);
		reset_n_i = 1'h1;
		step(4);
		`CHK({dix, dho, ipu, hpu, ioe}, 5'h16)
		`CHK({r_dix, r_dho, r_ioe}, 3'h0)
		iv = 1'h0; hv = 1'h1; pur = 16'h0008;
		step(4);
		`CHK({dix, dho, ipu, hpu}, 4'h4)
		`CHK({r_dix, r_dho}, 2'h0)
	endtask

	// Index pin as GPIO output and home as input, then the directions swapped.
	task t_gpio();
		dir = 16'h0004; dat = 16'h0004; ie = 1'h0; hv = 1'h1;
		// The reduced variant is usable only after this first load.
		load();
		`CHK({ioe, ipo}, 2'h3)
		`CHK({r_ioe, r_g3}, 2'h3)
		`CHK({hoe, g3, dho}, 3'h2)
		dir = 16'h0008; dat = 16'h0000; ie = 1'h1; iv = 1'h1; he = 1'h0;
		step(4);
		`CHK({ioe, g2, dix}, 3'h2)
		`CHK({hoe, hpo}, 2'h2)
	endtask

	// Both pins on their timer channels.
	task t_timer();
		pe = 16'h000c; ts = 16'h000c; t2o = 1'h1; t2e = 1'h1; ie = 1'h0; he = 1'h1; hv = 1'h1;
		load();
		`CHK({ioe, ipo, g2, t2i}, 4'hd)
		`CHK({hoe, t3i, dho, g3}, 4'h4)
	endtask

	// Slave mode: select from the peer, launched bits, then deselect.
	task t_slave();
		ia = 1'h1; ha = 1'h1; smode = 1'h1; hv = 1'h0; t2e = 1'h0;
		load();
		`CHK({ss, ioe, hoe, mf}, 4'hc)
		for (int i = 0; i < 4; i++) begin
			sbit = i[0];
			lch = 1'h1;
			step(1);
			lch = 1'h0;
			// Just after the launch edge the previous bit still stands on the pad.
			if (i > 0) `CHK(ipo, ~i[0])
			step(1);
			`CHK(ipo, i[0])
		end
		hv = 1'h1;
		step(4);
		`CHK({ss, ioe}, 2'h0)
	endtask

	// Master mode: data line is an input, low select flags arbitration.
	task t_master();
		smode = 1'h0; hv = 1'h0; ie = 1'h1; iv = 1'h1;
		step(4);
		`CHK({mf, ss, ioe, mi}, 4'h9)
		iv = 1'h0;
		step(4);
		`CHK(mi, 1'h0)
	endtask

	// Main sequence.
	initial begin
		t_reset();
		t_gpio();
		t_timer();
		t_slave();
		t_master();
		stop_test();
	end
endmodule
